//--- logic/srs_top.sv
/*
 * Digital control of the frequency synthesizer: reference oscillator enable
 * and bias, divided reference output, reference divider, fractional feedback
 * divide sequence, regulator settling and the selectable status output.
 * Assumes mclk is the reference clock, nrst is the chip enable pin, and the
 * analog sections hand their status in as asynchronous level pins.
 */
// What this block does
// - Oscillator runs when enable bit set
// - Two-bit crystal bias current select
// - Divided reference: 50:50, inverted
// - Even divide ratios 2 to 30
// - Divided reference defaults to eight
// - Zero divide field disables divided output
// - Reference divider 1 to 7 ticks PFD
// - Reference divider resets to one
// - Feedback: 8-bit integer, 15-bit fraction
// - Integer at least 23, at most 255
// - Frequency equals PFD times integer-plus-fraction
// - Halving option halves output frequency
// - Chip enable low erases all registers
// - Three-bit field selects status source
// - Status defaults to regulator ready
// - Calibration complete low during calibrations
// - Lock after five good cycles, lost on large error
// - Signal strength ready when measurement settled
// - Transmit low, receive high
`timescale 1ns/1ns
`include "srs_params.svh"

module srs_top #(
    parameter int INT_W = 8,
    parameter int FRAC_W = 15
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic coarse_cal_busy,
    input wire logic fine_cal_busy,
    input wire logic phase_err_small,
    input wire logic phase_err_large,
    input wire logic signal_strength_settled_flag,
    input wire logic rx_mode,
    output logic osc_run,
    output logic [1:0] crystal_bias_field,
    output logic output_halving_option,
    output logic [INT_W-1:0] fb_integer,
    output logic [FRAC_W-1:0] fb_fraction,
    output logic [INT_W:0] fb_divide_now,
    output logic pfd_tick,
    output logic reg_ready,
    output logic divided_reference_output,
    output logic selectable_status_output
);
    localparam int SYNC_W = 5;
    localparam int S_CAL_A = 0;
    localparam int S_CAL_B = 1;
    localparam int S_SMALL = 2;
    localparam int S_LARGE = 3;
    localparam int S_RSSI = 4;
    localparam logic [11:0] SETTLE_LAST = 12'(`SRS_REG_SETTLE_CYC - 1);

    srs_pkg::srs_top_state_t st_reg;
    srs_pkg::srs_top_state_t st_next;

    logic [SYNC_W-1:0] pins_raw;
    logic locked;
    logic divided_reference_output_raw;
    logic cal_done;
    logic tx_rx;
    logic status_sel;
    logic [INT_W-1:0] int_used;
    logic [FRAC_W:0] acc_sum;
    logic [31:0] read_mux;
    logic [31:0] stat_word;

    assign pins_raw[S_CAL_A] = coarse_cal_busy;
    assign pins_raw[S_CAL_B] = fine_cal_busy;
    assign pins_raw[S_SMALL] = phase_err_small;
    assign pins_raw[S_LARGE] = phase_err_large;
    assign pins_raw[S_RSSI] = signal_strength_settled_flag;

    // Lock detect looks at the resynchronised error levels once per PFD cycle.
    srs_lock_detect u_lock (
        .mclk(mclk),
        .nrst(nrst),
        .pfd_tick(st_reg.pfd_tick),
        .err_small(st_reg.sync2[S_SMALL]),
        .err_large(st_reg.sync2[S_LARGE]),
        .locked(locked)
    );

    srs_divided_reference_output_div #(
        .HALF_W(4)
    ) u_divided_reference_output (
        .mclk(mclk),
        .nrst(nrst),
        .half_ratio(st_reg.clk_div),
        .clk_out(divided_reference_output_raw)
    );

    // Tx/Rx is a same-clock level from the mode control, so it needs no resync.
    assign tx_rx = rx_mode;
    assign cal_done = ~(st_reg.sync2[S_CAL_A] | st_reg.sync2[S_CAL_B]);

    // Values below the pulse-swallow minimum would miscount, so they are raised.
    assign int_used = (st_reg.integ < `SRS_INT_MIN) ? `SRS_INT_MIN : st_reg.integ;
    assign acc_sum = {1'b0, st_reg.acc} + {1'b0, st_reg.frac};

    always_comb
    begin
        case (st_reg.mux_sel)
            srs_pkg::SRS_MUX_REG_READY:
                status_sel = st_reg.reg_ready;
            srs_pkg::SRS_MUX_CAL_DONE:
                status_sel = cal_done;
            srs_pkg::SRS_MUX_LOCK:
                status_sel = locked;
            srs_pkg::SRS_MUX_RSSI:
                status_sel = st_reg.sync2[S_RSSI];
            srs_pkg::SRS_MUX_TXRX:
                status_sel = tx_rx;
            default:
                status_sel = 1'b0;
        endcase
    end

    always_comb
    begin
        stat_word = '0;
        stat_word[`SRS_ST_REG_READY] = st_reg.reg_ready;
        stat_word[`SRS_ST_CAL_DONE] = cal_done;
        stat_word[`SRS_ST_LOCK] = locked;
        stat_word[`SRS_ST_RSSI] = st_reg.sync2[S_RSSI];
        stat_word[`SRS_ST_TXRX] = tx_rx;
        stat_word[`SRS_ST_N_MSB:`SRS_ST_N_LSB] = st_reg.n_now;
    end

    always_comb
    begin
        read_mux = '0;
        case (reg_addr)
            `SRS_OFF_N:
            begin
                read_mux[`SRS_FRAC_MSB:`SRS_FRAC_LSB] = st_reg.frac;
                read_mux[`SRS_INT_MSB:`SRS_INT_LSB] = st_reg.integ;
                read_mux[`SRS_MUX_MSB:`SRS_MUX_LSB] = st_reg.mux_sel;
            end
            `SRS_OFF_REF:
            begin
                read_mux[`SRS_RDIV_MSB:`SRS_RDIV_LSB] = st_reg.r_div;
                read_mux[`SRS_CLKDIV_MSB:`SRS_CLKDIV_LSB] = st_reg.clk_div;
                read_mux[`SRS_OSC_BIT] = st_reg.osc_en;
                read_mux[`SRS_BIAS_MSB:`SRS_BIAS_LSB] = st_reg.xbias;
                read_mux[`SRS_HALF_BIT] = st_reg.half;
            end
            `SRS_OFF_STAT:
                read_mux = stat_word;
            default:
                read_mux = '0;
        endcase
    end

    always_comb
    begin
        st_next = st_reg;

        // The second flop alone reads the first; logic reads only the second.
        st_next.sync1 = pins_raw;
        st_next.sync2 = st_reg.sync1;

        // Regulator settling time counted from chip enable going high.
        if (!st_reg.reg_ready)
        begin
            if (st_reg.settle_cnt == SETTLE_LAST)
                st_next.reg_ready = 1'b1;
            else
                st_next.settle_cnt = st_reg.settle_cnt + 12'h001;
        end

        // The serial side is unpowered until the regulator settles, so earlier
        // writes are dropped rather than half-applied.
        if (reg_wr && st_reg.reg_ready)
        begin
            case (reg_addr)
                `SRS_OFF_N:
                begin
                    st_next.frac = reg_wdata[`SRS_FRAC_MSB:`SRS_FRAC_LSB];
                    st_next.integ = reg_wdata[`SRS_INT_MSB:`SRS_INT_LSB];
                    st_next.mux_sel =
                        srs_pkg::srs_mux_sel_t'(reg_wdata[`SRS_MUX_MSB:`SRS_MUX_LSB]);
                end
                `SRS_OFF_REF:
                begin
                    st_next.r_div = reg_wdata[`SRS_RDIV_MSB:`SRS_RDIV_LSB];
                    st_next.clk_div = reg_wdata[`SRS_CLKDIV_MSB:`SRS_CLKDIV_LSB];
                    st_next.osc_en = reg_wdata[`SRS_OSC_BIT];
                    st_next.xbias = reg_wdata[`SRS_BIAS_MSB:`SRS_BIAS_LSB];
                    st_next.half = reg_wdata[`SRS_HALF_BIT];
                end
                default:
                begin
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe.
        st_next.rdata = reg_rd ? read_mux : 32'h0000_0000;

        st_next.osc_run = st_reg.osc_en;

        // Reference divider; a zero field behaves as divide by one.
        st_next.pfd_tick = 1'b0;
        if (st_reg.r_cnt + 3'h1 >= st_reg.r_div)
        begin
            st_next.r_cnt = '0;
            st_next.pfd_tick = 1'b1;
        end
        else
        begin
            st_next.r_cnt = st_reg.r_cnt + 3'h1;
        end

        // First-order sigma-delta: the carry adds one to the integer divide,
        // so the average ratio is integer plus fraction over 2^15.
        if (st_reg.pfd_tick)
        begin
            st_next.acc = acc_sum[FRAC_W-1:0];
            st_next.n_now = {1'b0, int_used} + {8'h00, acc_sum[FRAC_W]};
        end

        st_next.status = status_sel;
    end

    // Chip enable low clears every register to its power-up value.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg.settle_cnt <= 12'h000;
            st_reg.reg_ready <= 1'b0;
            st_reg.frac <= `SRS_RST_FRAC;
            st_reg.integ <= `SRS_RST_INT;
            st_reg.mux_sel <= srs_pkg::SRS_MUX_REG_READY;
            st_reg.clk_div <= `SRS_RST_CLKDIV;
            st_reg.r_div <= `SRS_RST_RDIV;
            st_reg.osc_en <= `SRS_RST_OSC_EN;
            st_reg.xbias <= `SRS_RST_BIAS;
            st_reg.half <= 1'b0;
            st_reg.osc_run <= 1'b0;
            st_reg.r_cnt <= 3'h0;
            st_reg.pfd_tick <= 1'b0;
            st_reg.acc <= 15'h0000;
            st_reg.n_now <= 9'h000;
            st_reg.status <= 1'b0;
            st_reg.rdata <= 32'h0000_0000;
            st_reg.sync1 <= 5'h00;
            st_reg.sync2 <= 5'h00;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign osc_run = st_reg.osc_run;
    assign crystal_bias_field = st_reg.xbias;
    assign output_halving_option = st_reg.half;
    assign fb_integer = st_reg.integ;
    assign fb_fraction = st_reg.frac;
    assign fb_divide_now = st_reg.n_now;
    assign pfd_tick = st_reg.pfd_tick;
    assign reg_ready = st_reg.reg_ready;
    assign divided_reference_output = divided_reference_output_raw;
    assign selectable_status_output = st_reg.status;
endmodule

//--- shared/srs_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the synthesizer
 * reference and status block.
 * Assumes a 50 MHz reference on mclk and byte addresses on the register port.
 */
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

`define SRS_OFF_N 8'h00
`define SRS_OFF_REF 8'h04
`define SRS_OFF_STAT 8'h08

`define SRS_FRAC_LSB 4
`define SRS_FRAC_MSB 18
`define SRS_INT_LSB 19
`define SRS_INT_MSB 26
`define SRS_MUX_LSB 29
`define SRS_MUX_MSB 31

`define SRS_RDIV_LSB 4
`define SRS_RDIV_MSB 6
`define SRS_CLKDIV_LSB 7
`define SRS_CLKDIV_MSB 10
`define SRS_OSC_BIT 12
`define SRS_BIAS_LSB 13
`define SRS_BIAS_MSB 14
`define SRS_HALF_BIT 18

`define SRS_ST_REG_READY 0
`define SRS_ST_CAL_DONE 1
`define SRS_ST_LOCK 2
`define SRS_ST_RSSI 3
`define SRS_ST_TXRX 4
`define SRS_ST_N_LSB 8
`define SRS_ST_N_MSB 16

`define SRS_RST_OSC_EN 1'b1
`define SRS_RST_BIAS 2'h0
`define SRS_RST_CLKDIV 4'h4
`define SRS_RST_RDIV 3'h1
`define SRS_RST_INT 8'h17
`define SRS_RST_FRAC 15'h0000
`define SRS_INT_MIN 8'h17
`define SRS_LOCK_CYCLES 3'h5

`define SRS_CLK_PERIOD_NS 20
`define SRS_REG_SETTLE_NS 50000
`define SRS_REG_SETTLE_CYC ((`SRS_REG_SETTLE_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)

`endif

//--- shared/srs_pkg.sv
/*
 * Types of the synthesizer reference and status block.
 * Assumes srs_params.svh for all numeric settings.
 */
package srs_pkg;

    typedef enum logic [2:0] {
        SRS_MUX_REG_READY = 3'b000,
        SRS_MUX_CAL_DONE = 3'b001,
        SRS_MUX_LOCK = 3'b010,
        SRS_MUX_RSSI = 3'b011,
        SRS_MUX_TXRX = 3'b100
    } srs_mux_sel_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic clk_out;
    } srs_divided_reference_output_state_t;

    typedef struct packed {
        logic [2:0] good_cnt;
        logic locked;
    } srs_lock_state_t;

    typedef struct packed {
        logic [11:0] settle_cnt;
        logic reg_ready;
        logic [14:0] frac;
        logic [7:0] integ;
        srs_mux_sel_t mux_sel;
        logic [3:0] clk_div;
        logic [2:0] r_div;
        logic osc_en;
        logic [1:0] xbias;
        logic half;
        logic osc_run;
        logic [2:0] r_cnt;
        logic pfd_tick;
        logic [14:0] acc;
        logic [8:0] n_now;
        logic status;
        logic [31:0] rdata;
        logic [4:0] sync1;
        logic [4:0] sync2;
    } srs_top_state_t;

endpackage

//--- logic/srs_divided_reference_output_div.sv
/*
 * Divided reference clock generator with a 50:50 duty cycle.
 * Assumes the reference is mclk and the half ratio field comes from a register.
 */
`timescale 1ns/1ns
`include "srs_params.svh"

module srs_divided_reference_output_div #(
    parameter int HALF_W = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [HALF_W-1:0] half_ratio,
    output logic clk_out
);
    srs_pkg::srs_divided_reference_output_state_t st_reg;
    srs_pkg::srs_divided_reference_output_state_t st_next;

    // The field holds half the divide ratio, so every nonzero code gives an even ratio; zero holds the output low.
    always_comb
    begin
        st_next = st_reg;
        if (half_ratio == '0)
        begin
            st_next.cnt = '0;
            st_next.clk_out = 1'b0;
        end
        else if (st_reg.cnt >= half_ratio - 4'h1)
        begin
            st_next.cnt = '0;
            st_next.clk_out = ~st_reg.clk_out;
        end
        else
        begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    // Starting high places the output in antiphase with the reference edges.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st_reg <= '{cnt: 4'h0, clk_out: 1'b1};
        else
            st_reg <= st_next;
    end

    assign clk_out = st_reg.clk_out;
endmodule

//--- logic/srs_lock_detect.sv
/*
 * Digital lock detect on phase detector cycles.
 * Assumes synchronised small and large phase error levels and a PFD tick.
 */
`timescale 1ns/1ns
`include "srs_params.svh"

module srs_lock_detect (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pfd_tick,
    input wire logic err_small,
    input wire logic err_large,
    output logic locked
);
    srs_pkg::srs_lock_state_t st_reg;
    srs_pkg::srs_lock_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (pfd_tick)
        begin
            if (err_large)
            begin
                st_next.locked = 1'b0;
                st_next.good_cnt = '0;
            end
            else if (err_small)
            begin
                if (st_reg.good_cnt == `SRS_LOCK_CYCLES - 3'h1)
                    st_next.locked = 1'b1;
                else
                    st_next.good_cnt = st_reg.good_cnt + 3'h1;
            end
            else
            begin
                st_next.good_cnt = '0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st_reg <= '{good_cnt: 3'h0, locked: 1'b0};
        else
            st_reg <= st_next;
    end

    assign locked = st_reg.locked;
endmodule

//--- tb/srs_top_chk.sv
/* Assertions on the ports of srs_top, bound into every instance of it.
   Assumes one clock domain and a byte-addressed register port. */
`timescale 1ns/1ns
module srs_top_chk #(
    parameter int INT_W = 8,
    parameter int FRAC_W = 15
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic osc_run,
    input wire logic [1:0] crystal_bias_field,
    input wire logic output_halving_option,
    input wire logic [INT_W-1:0] fb_integer,
    input wire logic [FRAC_W-1:0] fb_fraction,
    input wire logic [INT_W:0] fb_divide_now,
    input wire logic pfd_tick,
    input wire logic reg_ready,
    input wire logic divided_reference_output
);
    logic [11:0] up_cnt;
    logic wr0;
    logic wr4;
    assign wr0 = reg_wr && reg_ready && reg_addr == 8'h00;
    assign wr4 = reg_wr && reg_ready && reg_addr == 8'h04;
    // Saturates so that a long run cannot wrap back under the threshold.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            up_cnt <= 12'h000;
        else if (up_cnt != 12'hfff)
            up_cnt <= up_cnt + 12'h001;
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    a_ready_time: assert property (reg_ready == (up_cnt >= 12'h9c4))
        else $error("regulator ready at wrong time");
    a_int_write: assert property (wr0 |=> fb_integer == $past(reg_wdata[26:19]))
        else $error("integer field not written");
    a_frac_write: assert property (wr0 |=> fb_fraction == $past(reg_wdata[18:4]))
        else $error("fraction field not written");
    a_bias_half: assert property (wr4 |=> crystal_bias_field == $past(reg_wdata[14:13])
        && output_halving_option == $past(reg_wdata[18]))
        else $error("bias or halving not written");
    a_osc_follow: assert property (wr4 |-> ##2 osc_run == $past(reg_wdata[12], 2))
        else $error("oscillator does not follow enable");
    a_write_refused: assert property (reg_wr && !reg_ready |=> $stable(fb_integer))
        else $error("write taken before ready");
    a_stat_read: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata[0] == $past(reg_ready))
        else $error("status read wrong");
    a_div_range: assert property (pfd_tick |-> ##3 fb_divide_now inside {[9'h017:9'h100]})
        else $error("feedback divide out of range");
    a_clk_off: assert property (wr4 && reg_wdata[10:7] == 4'h0 |-> ##3 !divided_reference_output [*8])
        else $error("divided output not stopped");
    c_write: cover property (wr0);
    c_ready: cover property ($rose(reg_ready));
    c_clk_off: cover property (wr4 && reg_wdata[10:7] == 4'h0);
endmodule

bind srs_top srs_top_chk #(.INT_W(INT_W), .FRAC_W(FRAC_W)) u_srs_top_chk (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_run,
    .crystal_bias_field, .output_halving_option, .fb_integer, .fb_fraction,
    .fb_divide_now, .pfd_tick, .reg_ready, .divided_reference_output
);

//--- tb/srs_host_model.sv
/* Host model that programs the block over the register port.
   Assumes the status pin shows regulator ready after chip enable rises. */
`timescale 1ns/1ns
module srs_host_model (
    input wire logic mclk,
    input wire logic status,
    input wire logic [31:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // An ac-coupled reference keeps the oscillator on.
    localparam logic OSC_EN = 1'b1;
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // The port is dead until the regulator settles, so programming waits for the pin.
    task automatic wait_ready(output logic ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 4000 && !ok; i++)
        begin
            @(posedge mclk);
            ok = (status === 1'b1);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        // Read data stand for one cycle after the strobe edge; take them mid-cycle.
        @(negedge mclk);
        v = reg_rdata;
    endtask
endmodule

//--- tb/tb_srs_top.sv
/* Self-checking bench for srs_top with random divider settings.
   Assumes the checker binds itself into srs_top. */
`timescale 1ns/1ns
module tb_srs_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_wr, reg_rd, osc_run, output_halving_option, pfd_tick, reg_ready;
    logic coarse_cal_busy = 1'b0;
    logic fine_cal_busy = 1'b0;
    logic phase_err_small = 1'b0;
    logic phase_err_large = 1'b0;
    logic signal_strength_settled_flag = 1'b0;
    logic rx_mode = 1'b0;
    logic divided_reference_output, selectable_status_output;
    logic [1:0] crystal_bias_field;
    logic [7:0] fb_integer;
    logic [14:0] fb_fraction;
    logic [8:0] fb_divide_now;
    logic [31:0] d;
    logic [3:0] fvals [3] = '{4'h1, 4'h7, 4'hf};
    logic ok;
    int bad_count = 0;
    int n_checks = 0;
    int i, k, n;

    always #10 mclk = ~mclk;

    srs_top u_srs_top (
        .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .coarse_cal_busy, .fine_cal_busy, .phase_err_small, .phase_err_large,
        .signal_strength_settled_flag, .rx_mode, .osc_run, .crystal_bias_field,
        .output_halving_option, .fb_integer, .fb_fraction, .fb_divide_now,
        .pfd_tick, .reg_ready, .divided_reference_output, .selectable_status_output
    );
    srs_host_model u_srs_host_model (
        .mclk, .status(selectable_status_output), .reg_rdata, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        u_srs_host_model.wr(a, v);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        u_srs_host_model.rd(a, v);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [31:0] r00(input logic [2:0] m, input logic [7:0] nv,
                                        input logic [14:0] f);
        return {m, 2'h0, nv, f, 4'h0};
    endfunction
    function automatic logic [31:0] r04(input logic [2:0] r, input logic [3:0] f,
                                        input logic [1:0] b, input logic h);
        return {13'h0, h, 3'h0, b, u_srs_host_model.OSC_EN, 1'b0, f, r, 4'h0};
    endfunction
    function automatic logic mux_exp(input int c);
        case (c)
            0: return 1'b1;
            1: return !(coarse_cal_busy | fine_cal_busy);
            3: return signal_strength_settled_flag;
            4: return rx_mode;
            default: return 1'b0;
        endcase
    endfunction
    // First pass only lines up with an edge; the next two give high and low spans.
    task automatic clk_half(output int c1, output int c2);
        int t;
        int c;
        logic v;
        for (t = 0; t < 3; t++)
        begin
            v = divided_reference_output;
            c = 0;
            do
            begin
                @(posedge mclk);
                c++;
            end
            while (divided_reference_output === v && c < 80);
            c1 = c2;
            c2 = c;
        end
    endtask
    task automatic tick_gap(output int c);
        int t;
        for (t = 0; t < 2; t++)
        begin
            c = 0;
            do
            begin
                @(posedge mclk);
                c++;
            end
            while (pfd_tick !== 1'b1 && c < 40);
        end
    endtask

    initial
    begin
        #2000000;
        bad_count++;
        $display("MISMATCH watchdog expected done seen hang");
        final_report();
    end

    initial
    begin
        void'($urandom(25));
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        wr(8'h00, r00(3'h0, 8'h50, 15'h0));
        u_srs_host_model.wait_ready(ok);
        chk("ready", 32'h1, ok);
        rd(8'h00, d);
        chk("reg0 default", r00(3'h0, 8'h17, 15'h0), d);
        rd(8'h04, d);
        chk("reg4 default", r04(3'h1, 4'h4, 2'h0, 1'b0), d);
        clk_half(k, n);
        chk("divided_reference_output default", 32'h4, k);
        rd(8'h0c, d);
        chk("unmapped", 32'h0, d);
        rd(8'h08, d);
        chk("status ready", 32'h1, d[0]);
        for (i = 0; i < 20; i++)
        begin
            n = 23 + $urandom_range(232);
            k = $urandom_range(32767);
            wr(8'h00, r00(3'h0, 8'(n), 15'(k)));
            rd(8'h00, d);
            chk("reg0", r00(3'h0, 8'(n), 15'(k)), d);
            chk("int", n, fb_integer);
            chk("frac", k, fb_fraction);
        end
        wr(8'h04, r04(3'h1, 4'h4, 2'h3, 1'b1) & 32'hffffefff);
        repeat (3) @(posedge mclk);
        chk("osc off", 32'h0, osc_run);
        chk("bias", 32'h3, crystal_bias_field);
        chk("halve", 32'h1, output_halving_option);
        wr(8'h04, r04(3'h1, 4'h4, 2'h0, 1'b0));
        repeat (3) @(posedge mclk);
        chk("osc on", 32'h1, osc_run);
        wr(8'h00, r00(3'h0, 8'h1e, 15'h4000));
        repeat (4) @(posedge mclk);
        n = 0;
        repeat (16)
        begin
            @(posedge mclk);
            n += (fb_divide_now === 9'h01f);
        end
        chk("carries", 32'h8, n);
        wr(8'h00, r00(3'h0, 8'h0a, 15'h0));
        repeat (6) @(posedge mclk);
        chk("div min", 32'h17, fb_divide_now);
        for (i = 1; i < 8; i++)
        begin
            wr(8'h04, r04(3'(i), 4'h4, 2'h0, 1'b0));
            repeat (10) @(posedge mclk);
            tick_gap(k);
            chk("pfd gap", i, k);
        end
        foreach (fvals[j])
        begin
            wr(8'h04, r04(3'h1, fvals[j], 2'h0, 1'b0));
            clk_half(k, n);
            chk("divided_reference_output high", fvals[j], k);
            chk("divided_reference_output low", fvals[j], n);
        end
        wr(8'h04, r04(3'h1, 4'h0, 2'h0, 1'b0));
        repeat (5) @(posedge mclk);
        n = 0;
        repeat (40)
        begin
            @(posedge mclk);
            n += (divided_reference_output !== 1'b0);
        end
        chk("divided_reference_output stopped", 32'h0, n);
        for (k = 0; k < 3; k++)
        begin
            @(posedge mclk);
            coarse_cal_busy <= (k == 1);
            fine_cal_busy <= (k == 2);
            signal_strength_settled_flag <= k[0];
            rx_mode <= (k != 0);
            for (i = 0; i < 8; i++)
            begin
                wr(8'h00, r00(3'(i), 8'h17, 15'h0));
                repeat (6) @(posedge mclk);
                chk("status", mux_exp(i), selectable_status_output);
            end
        end
        wr(8'h04, r04(3'h7, 4'h4, 2'h0, 1'b0));
        wr(8'h00, r00(3'h2, 8'h17, 15'h0));
        @(posedge mclk);
        phase_err_small <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("lock early", 32'h0, selectable_status_output);
        repeat (60) @(posedge mclk);
        chk("lock", 32'h1, selectable_status_output);
        phase_err_small <= 1'b0;
        phase_err_large <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("unlock", 32'h0, selectable_status_output);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("osc in reset", 32'h0, osc_run);
        nrst <= 1'b1;
        u_srs_host_model.wait_ready(ok);
        chk("ready again", 32'h1, ok);
        rd(8'h04, d);
        chk("reg4 erased", r04(3'h1, 4'h4, 2'h0, 1'b0), d);
        final_report();
    end
endmodule
